//--- inc/gpxp_pkg.sv
// package of register offsets, field positions and reset values for the gpio expander port
`default_nettype none
package gpxp_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 16;
   localparam logic [4:0] OFS_LEVEL = 5'h10;
   localparam logic [4:0] OFS_DIRECTION = 5'h11;
   localparam logic [4:0] OFS_DRIVER_TYPE = 5'h12;
   localparam logic [4:0] OFS_INPUT_STATE = 5'h13;
   localparam logic PAGE_STATUS = 1'b0;
   localparam logic PAGE_CONTROL = 1'b1;
   localparam int unsigned FIELD_HI_LSB = 8;
   localparam int unsigned FIELD_LO_LSB = 0;
   localparam logic [7:0] RST_OUT_LEVEL = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [7:0] RST_DRIVER_TYPE = 8'h00;
   localparam logic [7:0] RST_INPUT_STATE = 8'h00;
endpackage
`default_nettype wire

//--- hdl/gpxp_pin_cell.sv
// one gpio pin cell: driver enable, level and pull-down control
`default_nettype none
module gpxp_pin_cell (
   input wire logic is_output,
   input wire logic out_level,
   input wire logic open_drain,
   input wire logic hi_z,
   output logic pad_o,
   output logic pad_oe,
   output logic pull_down_en
);
   // open drain only sinks; a high level releases the pin
   assign pad_o = open_drain ? 1'b0 : out_level;
   assign pad_oe = is_output & (~open_drain | ~out_level); // see RULE_09
   assign pull_down_en = ~is_output & ~hi_z; // see RULE_05
endmodule
`default_nettype wire

//--- hdl/gpxp_port.sv
// gpio expander port: paged register file and eight pin cells
//
// Notes on behaviour
// RULE_01 - write-only output level, low eight bits drive pins set as outputs; reset low.
// RULE_02 - output level ignores upper byte on write and never reads back.
// RULE_03 - direction bits 15:8, pin 7 in bit 15; 1 output, 0 input.
// RULE_04 - driver type bits 15:8; 0 push-pull, 1 open drain; outputs only.
// RULE_05 - input state bits 15:8; 0 pull-down, 1 high impedance; inputs only.
// RULE_06 - level register read-only, bits 7:0 give live pin levels always.
// RULE_07 - level register reads zero in the upper eight bits.
// RULE_08 - offset 10h reads level in page 0, writes output level in page 1.
// RULE_09 - an input pin keeps its driver off whatever the output settings.
`default_nettype none
module gpxp_port #(
   parameter int unsigned PINS = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic reg_page,
   input wire logic [gpxp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gpxp_pkg::DATA_W-1:0] reg_wdata,
   output logic [gpxp_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [PINS-1:0] pin_i,
   output logic [PINS-1:0] pin_o,
   output logic [PINS-1:0] pin_oe,
   output logic [PINS-1:0] pin_pull_down
);
   logic [PINS-1:0] out_level_bits_q, out_level_bits_d;
   logic [PINS-1:0] direction_q, direction_d;
   logic [PINS-1:0] drive_type_bits_q, drive_type_bits_d;
   logic [PINS-1:0] in_state_bits_q, in_state_bits_d;
   logic [gpxp_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic wr_ctl;

   assign wr_ctl = reg_wr & (reg_page == gpxp_pkg::PAGE_CONTROL);

   always_comb begin
      out_level_bits_d = out_level_bits_q;
      direction_d = direction_q;
      drive_type_bits_d = drive_type_bits_q;
      in_state_bits_d = in_state_bits_q;
      if (wr_ctl) begin
         case (reg_addr)
            gpxp_pkg::OFS_LEVEL: begin
               out_level_bits_d = reg_wdata[gpxp_pkg::FIELD_LO_LSB +: PINS]; // see RULE_01 see RULE_02 see RULE_08
            end
            gpxp_pkg::OFS_DIRECTION: begin
               direction_d = reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS]; // see RULE_03
            end
            gpxp_pkg::OFS_DRIVER_TYPE: begin
               drive_type_bits_d = reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS]; // see RULE_04
            end
            gpxp_pkg::OFS_INPUT_STATE: begin
               in_state_bits_d = reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS]; // see RULE_05
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = '0;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         if (reg_page == gpxp_pkg::PAGE_STATUS) begin
            case (reg_addr)
               // upper byte stays zero; live level regardless of direction
               gpxp_pkg::OFS_LEVEL: rdata_d[gpxp_pkg::FIELD_LO_LSB +: PINS] = pin_i; // see RULE_06 see RULE_07 see RULE_08
               default: rdata_d = '0;
            endcase
         end else begin
            case (reg_addr)
               gpxp_pkg::OFS_DIRECTION: rdata_d[gpxp_pkg::FIELD_HI_LSB +: PINS] = direction_q;
               gpxp_pkg::OFS_DRIVER_TYPE: rdata_d[gpxp_pkg::FIELD_HI_LSB +: PINS] = drive_type_bits_q;
               gpxp_pkg::OFS_INPUT_STATE: rdata_d[gpxp_pkg::FIELD_HI_LSB +: PINS] = in_state_bits_q;
               // output level is write-only: page 1 offset 10h reads zero
               default: rdata_d = '0; // see RULE_02
            endcase
         end
      end
   end

   // configuration group
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_level_bits_q <= gpxp_pkg::RST_OUT_LEVEL; // see RULE_01
         direction_q <= gpxp_pkg::RST_DIRECTION; // see RULE_03
         drive_type_bits_q <= gpxp_pkg::RST_DRIVER_TYPE; // see RULE_04
         in_state_bits_q <= gpxp_pkg::RST_INPUT_STATE; // see RULE_05
      end else if (clk_en) begin
         out_level_bits_q <= out_level_bits_d;
         direction_q <= direction_d;
         drive_type_bits_q <= drive_type_bits_d;
         in_state_bits_q <= in_state_bits_d;
      end
   end

   // read group; a low enable stretches the answer pulse, a limitation callers must respect
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= '0;
         rvalid_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;

   // pin cells are purely combinational so a register write shows on the pins at the same edge that loads the register
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         gpxp_pin_cell u_cell (
            .is_output(direction_q[g]),
            .out_level(out_level_bits_q[g]),
            .open_drain(drive_type_bits_q[g]),
            .hi_z(in_state_bits_q[g]),
            .pad_o(pin_o[g]),
            .pad_oe(pin_oe[g]),
            .pull_down_en(pin_pull_down[g])
         );
      end
   endgenerate

   // register port checks; writes land one edge after they are taken
   AST_INPUT_NO_DRIVE: assert property ( // see RULE_09
      @(posedge clk_sys) disable iff (rst)
      (pin_oe & ~direction_q) == '0
   ) else $error("input pin driven");

   AST_OUT_LEVEL_WRITE: assert property ( // see RULE_01
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_ctl && reg_addr == gpxp_pkg::OFS_LEVEL)
      |=> out_level_bits_q == $past(reg_wdata[gpxp_pkg::FIELD_LO_LSB +: PINS])
   ) else $error("output level not written");

   AST_OUT_LEVEL_KEEPS_OTHERS: assert property ( // see RULE_02
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_ctl && reg_addr == gpxp_pkg::OFS_LEVEL)
      |=> $stable(direction_q) && $stable(drive_type_bits_q) && $stable(in_state_bits_q)
   ) else $error("output level write spilled");

   AST_DIR_WRITE: assert property ( // see RULE_03
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_ctl && reg_addr == gpxp_pkg::OFS_DIRECTION)
      |=> direction_q == $past(reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS])
   ) else $error("direction not written");

   AST_DRV_TYPE_WRITE: assert property ( // see RULE_04
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_ctl && reg_addr == gpxp_pkg::OFS_DRIVER_TYPE)
      |=> drive_type_bits_q == $past(reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS])
   ) else $error("driver type not written");

   AST_IN_STATE_WRITE: assert property ( // see RULE_05
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_ctl && reg_addr == gpxp_pkg::OFS_INPUT_STATE)
      |=> in_state_bits_q == $past(reg_wdata[gpxp_pkg::FIELD_HI_LSB +: PINS])
   ) else $error("input state not written");

   AST_PULL_DOWN: assert property ( // see RULE_05
      @(posedge clk_sys) disable iff (rst)
      pin_pull_down == (~direction_q & ~in_state_bits_q)
   ) else $error("pull-down wrong");

   AST_LEVEL_READ: assert property ( // see RULE_06
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_STATUS && reg_addr == gpxp_pkg::OFS_LEVEL)
      |=> reg_rvalid && reg_rdata[gpxp_pkg::FIELD_LO_LSB +: PINS] == $past(pin_i)
   ) else $error("level read wrong");

   AST_LEVEL_UPPER_ZERO: assert property ( // see RULE_07
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_STATUS)
      |=> reg_rdata[gpxp_pkg::DATA_W-1:gpxp_pkg::FIELD_HI_LSB] == '0
   ) else $error("upper byte not zero");

   AST_OUT_LEVEL_NO_READ: assert property ( // see RULE_02
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_CONTROL && reg_addr == gpxp_pkg::OFS_LEVEL)
      |=> reg_rdata == '0
   ) else $error("output level read back");

   AST_PAGE0_NO_WRITE: assert property ( // see RULE_08
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_wr && reg_page == gpxp_pkg::PAGE_STATUS)
      |=> $stable(out_level_bits_q) && $stable(direction_q)
         && $stable(drive_type_bits_q) && $stable(in_state_bits_q)
   ) else $error("page 0 wrote a control register");

   AST_DIR_READBACK: assert property ( // see RULE_03
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_CONTROL && reg_addr == gpxp_pkg::OFS_DIRECTION)
      |=> reg_rdata[gpxp_pkg::FIELD_HI_LSB +: PINS] == $past(direction_q) && reg_rdata[7:0] == 8'h00
   ) else $error("direction read back wrong");

   AST_DRV_TYPE_READBACK: assert property ( // see RULE_04
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_CONTROL && reg_addr == gpxp_pkg::OFS_DRIVER_TYPE)
      |=> reg_rdata[gpxp_pkg::FIELD_HI_LSB +: PINS] == $past(drive_type_bits_q) && reg_rdata[7:0] == 8'h00
   ) else $error("driver type read back wrong");

   AST_IN_STATE_READBACK: assert property ( // see RULE_05
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && reg_page == gpxp_pkg::PAGE_CONTROL && reg_addr == gpxp_pkg::OFS_INPUT_STATE)
      |=> reg_rdata[gpxp_pkg::FIELD_HI_LSB +: PINS] == $past(in_state_bits_q) && reg_rdata[7:0] == 8'h00
   ) else $error("input state read back wrong");

   AST_RVALID_PULSE: assert property ( // see RULE_06
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd)
      |=> reg_rvalid
   ) else $error("read not answered");

   AST_RVALID_IDLE: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && !reg_rd)
      |=> !reg_rvalid && reg_rdata == '0
   ) else $error("answer without read");

   AST_UNMAPPED_READ_ZERO: assert property (
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && (reg_addr < gpxp_pkg::OFS_LEVEL || reg_addr > gpxp_pkg::OFS_INPUT_STATE))
      |=> reg_rdata == '0
   ) else $error("unmapped offset read not zero");

   AST_FREEZE_CONFIG: assert property (
      @(posedge clk_sys) disable iff (rst)
      !clk_en
      |=> $stable(out_level_bits_q) && $stable(direction_q)
         && $stable(drive_type_bits_q) && $stable(in_state_bits_q)
   ) else $error("configuration moved while frozen");

   AST_FREEZE_READ: assert property (
      @(posedge clk_sys) disable iff (rst)
      !clk_en
      |=> $stable(reg_rvalid) && $stable(reg_rdata)
   ) else $error("read answer moved while frozen");

   AST_RESET_STATE: assert property ( // see RULE_03
      @(posedge clk_sys)
      rst
      |=> pin_oe == '0 && pin_o == '0 && pin_pull_down == '1 && !reg_rvalid && reg_rdata == '0
   ) else $error("reset state wrong");

   AST_READ_NO_SIDE_EFFECT: assert property ( // see RULE_06
      @(posedge clk_sys) disable iff (rst)
      (clk_en && reg_rd && !reg_wr)
      |=> $stable(out_level_bits_q) && $stable(direction_q)
         && $stable(drive_type_bits_q) && $stable(in_state_bits_q)
   ) else $error("read changed a control register");

   // per pin checks of what the pad cell drives
   generate
      for (g = 0; g < PINS; g++) begin : g_pin_chk
         AST_CMOS_DRIVE: assert property ( // see RULE_04
            @(posedge clk_sys) disable iff (rst)
            (direction_q[g] && !drive_type_bits_q[g])
            |-> pin_oe[g] && pin_o[g] == out_level_bits_q[g]
         ) else $error("push-pull pin not driven");

         AST_OD_HIGH_RELEASE: assert property ( // see RULE_04
            @(posedge clk_sys) disable iff (rst)
            (direction_q[g] && drive_type_bits_q[g] && out_level_bits_q[g])
            |-> !pin_oe[g]
         ) else $error("open drain high drives");

         AST_OD_LOW_SINK: assert property ( // see RULE_04
            @(posedge clk_sys) disable iff (rst)
            (direction_q[g] && drive_type_bits_q[g] && !out_level_bits_q[g])
            |-> pin_oe[g] && !pin_o[g]
         ) else $error("open drain low not sunk");

         AST_PIN_LEVEL_OUT: assert property ( // see RULE_01
            @(posedge clk_sys) disable iff (rst)
            (direction_q[g] && pin_oe[g])
            |-> pin_o[g] == out_level_bits_q[g]
         ) else $error("driven level wrong");

         AST_INPUT_OFF: assert property ( // see RULE_09
            @(posedge clk_sys) disable iff (rst)
            !direction_q[g]
            |-> !pin_oe[g]
         ) else $error("input pin driver on");

         AST_INPUT_PULL: assert property ( // see RULE_05
            @(posedge clk_sys) disable iff (rst)
            !direction_q[g]
            |-> pin_pull_down[g] == !in_state_bits_q[g]
         ) else $error("input pull-down wrong");

         AST_OUTPUT_NO_PULL: assert property ( // see RULE_05
            @(posedge clk_sys) disable iff (rst)
            direction_q[g]
            |-> !pin_pull_down[g]
         ) else $error("output pin pulled down");
      end
   endgenerate
endmodule
`default_nettype wire

//--- bench/gpxp_host_model.sv
// host controller model driving the paged register port
`default_nettype none
module gpxp_host_model (
   input wire logic clk_sys,
   output logic reg_page,
   output logic [gpxp_pkg::ADDR_W-1:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [gpxp_pkg::DATA_W-1:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_page = 1'b0;
      reg_addr = 5'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   // one request, taken at the second edge; then the strobes drop and address and write data show inverted stale values
   task automatic acc(input logic pg, input logic [4:0] a, input logic w, input logic r, input logic [15:0] d);
      @(posedge clk_sys);
      reg_page <= pg;
      reg_addr <= a;
      reg_wr <= w;
      reg_rd <= r;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule
`default_nettype wire

//--- bench/gpxp_port_tb.sv
// self-checking bench for the gpio expander port
`default_nettype none
module gpxp_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst, en, reg_page, reg_wr, reg_rd, reg_rvalid;
   logic [4:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [7:0] pin_i, pin_o, pin_oe, pin_pull_down, ext, dir, od, hiz, lvl;
   logic [15:0] expq[$];
   logic [31:0] r;
   int err_count = 0;
   int n_compared = 0;
   // pad: driven level, else pull-down, else whatever the board puts there
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ~pin_pull_down & ext);
   gpxp_host_model gpxp_host_model_i (.clk_sys(clk_sys), .reg_page(reg_page), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   gpxp_port #(.PINS(8)) gpxp_port_i (.clk_sys(clk_sys), .rst(rst), .clk_en(en), .reg_page(reg_page),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pull_down(pin_pull_down));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rd(input logic pg, input logic [4:0] a, input logic [15:0] e);
      expq.push_back(e);
      gpxp_host_model_i.acc(pg, a, 1'b0, 1'b1, 16'h0000);
   endtask
   task automatic pins();
      #1;
      chk("pin_oe", {8'h00, dir & (~od | ~lvl)}, {8'h00, pin_oe});
      chk("pin_o", {8'h00, ~od & lvl}, {8'h00, pin_o});
      chk("pin_pull_down", {8'h00, ~dir & ~hiz}, {8'h00, pin_pull_down});
   endtask
   // sampled mid-cycle so the pulse has settled
   always @(negedge clk_sys) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0) chk("spare rvalid", 16'h0000, 16'hffff);
         else chk("reg_rdata", expq.pop_front(), reg_rdata);
      end
   end
   initial begin
      #200000;
      err_count++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      ext = 8'h00;
      en = 1'b1;
      {dir, od, hiz, lvl} = '0;
      void'($urandom(32'h860a0d51));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      pins();
      rd(1'b1, 5'h1f, 16'h0000);
      for (int i = 0; i < 60; i++) begin
         r = $urandom;
         // page 0 writes must leave every control register alone
         gpxp_host_model_i.acc(r[24], gpxp_pkg::OFS_LEVEL + 5'(r[26:25]), 1'b1, 1'b0, r[15:0]);
         ext <= r[23:16];
         if (r[24]) begin
            case (r[26:25])
               2'd0: lvl = r[7:0];
               2'd1: dir = r[15:8];
               2'd2: od = r[15:8];
               default: hiz = r[15:8];
            endcase
         end
         pins();
         rd(1'b1, gpxp_pkg::OFS_LEVEL, 16'h0000);
         rd(1'b1, gpxp_pkg::OFS_DIRECTION, {dir, 8'h00});
         rd(1'b1, gpxp_pkg::OFS_DRIVER_TYPE, {od, 8'h00});
         rd(1'b1, gpxp_pkg::OFS_INPUT_STATE, {hiz, 8'h00});
         rd(1'b0, gpxp_pkg::OFS_LEVEL, {8'h00, (dir & lvl & (~od | ext)) | (~dir & hiz & ext)});
      end
      // a frozen enable drops a write, yet reset still acts
      repeat (2) @(posedge clk_sys);
      en <= 1'b0;
      gpxp_host_model_i.acc(1'b1, gpxp_pkg::OFS_DIRECTION, 1'b1, 1'b0, ~{dir, 8'h00});
      pins();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      en <= 1'b1;
      {dir, od, hiz, lvl} = '0;
      pins();
      rd(1'b1, gpxp_pkg::OFS_DIRECTION, 16'h0000);
      repeat (4) @(posedge clk_sys);
      chk("pending reads", 16'h0000, 16'(expq.size()));
      conclude();
   end
endmodule
`default_nettype wire
